// >>> logic/ladder_decoder_pkg.sv
// Types shared by the ladder opcode decoder files
package ladder_decoder_pkg;

   // ***********************************************
   // Operation classes
   // ***********************************************
   typedef enum logic [4:0] {
      OP_NOP,
      OP_AND,
      OP_OR,
      OP_LOAD_EDGE,
      OP_NEGATE,
      OP_BLK_AND,
      OP_BLK_OR,
      OP_PUSH,
      OP_PEEK,
      OP_POP,
      OP_LATCH_ON,
      OP_LATCH_CLEAR,
      OP_COIL,
      OP_LABEL_JUMP,
      OP_LABEL_IRQ,
      OP_MAIN_END,
      OP_PROG_FINISH,
      OP_JUMP,
      OP_CALL,
      OP_SUB_RET,
      OP_LOOP_OPEN,
      OP_LOOP_CLOSE,
      OP_IRQ_RET,
      OP_IRQ_ON,
      OP_IRQ_OFF,
      OP_COMPARE,
      OP_RANGE,
      OP_TRANSFER,
      OP_ILLEGAL
   } op_class_t;

endpackage

// >>> logic/ladder_decoder_regs.svh
// Opcode values, field positions, widths and reset values of the ladder opcode decoder
`ifndef LADDER_DECODER_REGS_SVH
`define LADDER_DECODER_REGS_SVH

// ***********************************************
// Widths and field positions
// ***********************************************
`define LD_WORD_W            16
`define LD_IDX_W             8
`define LD_IDX_DEPTH         256
`define LD_PULSE_BIT         11
`define LD_DWORD_BIT         12
`define LD_GRP_HI            15
`define LD_GRP_LO            13
`define LD_APPLIED_GRP       3'h1
`define LD_BASE_MASK         16'hE7FF

// ***********************************************
// Reset values
// ***********************************************
`define LD_BIT_RST           1'h0
`define LD_WORD_RST          16'h0000

// ***********************************************
// Contact and block opcodes
// ***********************************************
`define OPC_AND_OPEN         16'h4065
`define OPC_AND_NOT_CONTACT  16'h4005
`define OPC_OR_OPEN          16'h4066
`define OPC_OR_NOT_CONTACT   16'h4046
`define OPC_LOAD_RISING      16'h4821
`define OPC_LOAD_FALLING     16'h4841
`define OPC_AND_RISING       16'h4825
`define OPC_AND_FALLING      16'h4845
`define OPC_OR_RISING        16'h4806
`define OPC_OR_FALLING       16'h4826
`define OPC_NEGATE_RESULT    16'h4016
`define OPC_SERIES_BLK_JOIN  16'h4007
`define OPC_PARALLEL_BLK_JOIN 16'h4008
`define OPC_STACK_PUSH       16'h4009
`define OPC_STACK_PEEK       16'h402A
`define OPC_STACK_POP        16'h400A

// ***********************************************
// Coil and structure opcodes
// ***********************************************
`define OPC_LATCH_ON         16'h2024
`define OPC_LATCH_CLEAR      16'h2004
`define OPC_COIL_DRIVE       16'h2002
`define OPC_MAIN_BODY_END    16'h6003
`define OPC_EMPTY_LINE       16'h8011
`define OPC_JUMP_LABEL       16'h6051
`define OPC_IRQ_LABEL        16'h6031
`define OPC_PROG_FINISH      16'h6023

// ***********************************************
// Flow, interrupt and applied base opcodes
// ***********************************************
`define OPC_COND_JUMP        16'h200D
`define OPC_SUB_CALL         16'h200E
`define OPC_SUB_RETURN       16'h600F
`define OPC_LOOP_OPEN        16'h400B
`define OPC_LOOP_CLOSE       16'h400C
`define OPC_IRQ_HANDLER_RETURN 16'h6010
`define OPC_IRQ_GLOBAL_ON    16'h8012
`define OPC_IRQ_GLOBAL_OFF   16'h8013
`define OPC_COMPARE_WORDS    16'h2201
`define OPC_RANGE_COMPARE    16'h2202
`define OPC_TRANSFER_WORD    16'h2018

`endif

// >>> logic/ladder_edge_memory.sv
// Per-instance previous-condition bit store for edge and pulsed instructions
`include "ladder_decoder_regs.svh"

module ladder_edge_memory (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic [`LD_IDX_W-1:0]  i_idx,
   input  wire logic                  i_wr_en,
   input  wire logic                  i_wr_bit,
   output logic                       o_prev_bit
);

   logic [`LD_IDX_DEPTH-1:0] prev_mem_ff;

   // ***********************************************
   // Storage
   // ***********************************************
   // Cleared at reset so the first scan sees every condition as previously false
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev_mem_ff <= '0;
      end else if (i_wr_en) begin
         prev_mem_ff[i_idx] <= i_wr_bit;
      end
   end

   assign o_prev_bit = prev_mem_ff[i_idx];

   AST_PREV_STORED: assert property (@(posedge i_clk) disable iff (i_rst)
      i_wr_en ##1 (i_idx == $past(i_idx)) |-> o_prev_bit == $past(i_wr_bit))
      else $error("Stored previous-condition bit not read back");

endmodule

// >>> logic/ladder_opcode_decoder.sv
// Ladder instruction word decoder with edge qualification and global interrupt enable
`include "ladder_decoder_regs.svh"

module ladder_opcode_decoder (
   input  wire logic                          I_CLK_SYS,
   input  wire logic                          I_RST,
   input  wire logic                          I_INSTR_VALID,
   input  wire logic [`LD_WORD_W-1:0]         I_INSTR_WORD,
   input  wire logic [`LD_IDX_W-1:0]          I_INSTR_INDEX,
   input  wire logic                          I_OPERAND_BIT,
   input  wire logic                          I_RESULT,
   input  wire logic                          I_ERROR_CLR,
   output logic                               O_VALID,
   output ladder_decoder_pkg::op_class_t      O_OP_CLASS,
   output logic                               O_INV_OPERAND,
   output logic                               O_EDGE_RISE,
   output logic                               O_EDGE_FALL,
   output logic                               O_PULSED,
   output logic                               O_DWORD,
   output logic                               O_FIRE,
   output logic                               O_ILLEGAL,
   output logic                               O_ERROR_FLAG,
   output logic                               O_IRQ_ENABLE
);
   import ladder_decoder_pkg::*;

   // ***********************************************
   // Declarations
   // ***********************************************
   op_class_t               nxt_class;
   logic                    nxt_inv;
   logic                    nxt_rise;
   logic                    nxt_fall;
   logic                    nxt_pulsed;
   logic                    nxt_dword;
   logic                    nxt_fire;
   logic                    edge_en;
   logic                    use_result;
   logic                    sample_bit;
   logic                    prev_bit;
   logic [`LD_WORD_W-1:0]   base_word;
   logic                    word_valid;

   op_class_t               class_ff;
   logic                    valid_ff;
   logic                    inv_ff;
   logic                    rise_ff;
   logic                    fall_ff;
   logic                    pulsed_ff;
   logic                    dword_ff;
   logic                    fire_ff;
   logic                    illegal_ff;
   logic                    error_ff;
   logic                    irq_en_ff;

   assign word_valid = I_INSTR_VALID;
   assign base_word  = I_INSTR_WORD & `LD_BASE_MASK;
   assign sample_bit = use_result ? I_RESULT : I_OPERAND_BIT;

   // ***********************************************
   // Opcode decode
   // ***********************************************
   always_comb begin
      nxt_class  = OP_ILLEGAL;
      nxt_inv    = 1'h0;
      nxt_rise   = 1'h0;
      nxt_fall   = 1'h0;
      nxt_pulsed = 1'h0;
      nxt_dword  = 1'h0;
      use_result = 1'h0;
      case (I_INSTR_WORD)
         `OPC_AND_OPEN: nxt_class = OP_AND;
         `OPC_AND_NOT_CONTACT: begin
            nxt_class = OP_AND;
            nxt_inv   = 1'h1;
         end
         `OPC_OR_OPEN: nxt_class = OP_OR;
         `OPC_OR_NOT_CONTACT: begin
            nxt_class = OP_OR;
            nxt_inv   = 1'h1;
         end
         `OPC_LOAD_RISING: begin
            nxt_class = OP_LOAD_EDGE;
            nxt_rise  = 1'h1;
         end
         `OPC_LOAD_FALLING: begin
            nxt_class = OP_LOAD_EDGE;
            nxt_fall  = 1'h1;
         end
         `OPC_AND_RISING: begin
            nxt_class = OP_AND;
            nxt_rise  = 1'h1;
         end
         `OPC_AND_FALLING: begin
            nxt_class = OP_AND;
            nxt_fall  = 1'h1;
         end
         `OPC_OR_RISING: begin
            nxt_class = OP_OR;
            nxt_rise  = 1'h1;
         end
         `OPC_OR_FALLING: begin
            nxt_class = OP_OR;
            nxt_fall  = 1'h1;
         end
         `OPC_NEGATE_RESULT: nxt_class = OP_NEGATE;
         `OPC_SERIES_BLK_JOIN: nxt_class = OP_BLK_AND;
         `OPC_PARALLEL_BLK_JOIN: nxt_class = OP_BLK_OR;
         `OPC_STACK_PUSH: nxt_class = OP_PUSH;
         `OPC_STACK_PEEK: nxt_class = OP_PEEK;
         `OPC_STACK_POP: nxt_class = OP_POP;
         `OPC_LATCH_ON: nxt_class = OP_LATCH_ON;
         `OPC_LATCH_CLEAR: nxt_class = OP_LATCH_CLEAR;
         `OPC_COIL_DRIVE: nxt_class = OP_COIL;
         `OPC_EMPTY_LINE: nxt_class = OP_NOP;
         `OPC_JUMP_LABEL: nxt_class = OP_LABEL_JUMP;
         `OPC_IRQ_LABEL: nxt_class = OP_LABEL_IRQ;
         `OPC_MAIN_BODY_END: nxt_class = OP_MAIN_END;
         `OPC_PROG_FINISH: nxt_class = OP_PROG_FINISH;
         `OPC_SUB_RETURN: nxt_class = OP_SUB_RET;
         `OPC_LOOP_OPEN: nxt_class = OP_LOOP_OPEN;
         `OPC_LOOP_CLOSE: nxt_class = OP_LOOP_CLOSE;
         `OPC_IRQ_HANDLER_RETURN: nxt_class = OP_IRQ_RET;
         `OPC_IRQ_GLOBAL_ON: nxt_class = OP_IRQ_ON;
         `OPC_IRQ_GLOBAL_OFF: nxt_class = OP_IRQ_OFF;
         default: begin
            if (I_INSTR_WORD[`LD_GRP_HI:`LD_GRP_LO] == `LD_APPLIED_GRP) begin
               nxt_pulsed = I_INSTR_WORD[`LD_PULSE_BIT];
               nxt_dword  = I_INSTR_WORD[`LD_DWORD_BIT];
               use_result = 1'h1;
               case (base_word)
                  `OPC_COMPARE_WORDS: nxt_class = OP_COMPARE;
                  `OPC_RANGE_COMPARE: nxt_class = OP_RANGE;
                  `OPC_TRANSFER_WORD: nxt_class = OP_TRANSFER;
                  `OPC_COND_JUMP: begin
                     if (!nxt_dword) begin
                        nxt_class = OP_JUMP;
                     end
                  end
                  `OPC_SUB_CALL: begin
                     if (!nxt_dword) begin
                        nxt_class = OP_CALL;
                     end
                  end
                  default: nxt_class = OP_ILLEGAL;
               endcase
            end
         end
      endcase
      if (nxt_class == OP_ILLEGAL) begin
         nxt_pulsed = 1'h0;
         nxt_dword  = 1'h0;
         use_result = 1'h0;
      end
   end

   // ***********************************************
   // Edge qualification
   // ***********************************************
   assign edge_en = nxt_rise | nxt_fall | nxt_pulsed;

   // Single shared store keeps area small; instance index must be unique per program line
   ladder_edge_memory u_edge_memory (
      .i_clk      (I_CLK_SYS),
      .i_rst      (I_RST),
      .i_idx      (I_INSTR_INDEX),
      .i_wr_en    (word_valid & edge_en),
      .i_wr_bit   (sample_bit),
      .o_prev_bit (prev_bit)
   );

   always_comb begin
      nxt_fire = 1'h0;
      if (nxt_fall) begin
         nxt_fire = ~sample_bit & prev_bit;
      end else if (edge_en) begin
         nxt_fire = sample_bit & ~prev_bit;
      end else if ((nxt_class != OP_NOP) && (nxt_class != OP_ILLEGAL)) begin
         nxt_fire = 1'h1;
      end
   end

   // ***********************************************
   // Decoded output registers
   // ***********************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         valid_ff   <= `LD_BIT_RST;
         fire_ff    <= `LD_BIT_RST;
         illegal_ff <= `LD_BIT_RST;
      end else begin
         valid_ff   <= word_valid;
         fire_ff    <= word_valid & nxt_fire;
         illegal_ff <= word_valid & (nxt_class == OP_ILLEGAL);
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         class_ff  <= OP_NOP;
         inv_ff    <= `LD_BIT_RST;
         rise_ff   <= `LD_BIT_RST;
         fall_ff   <= `LD_BIT_RST;
         pulsed_ff <= `LD_BIT_RST;
         dword_ff  <= `LD_BIT_RST;
      end else if (word_valid) begin
         class_ff  <= nxt_class;
         inv_ff    <= nxt_inv;
         rise_ff   <= nxt_rise;
         fall_ff   <= nxt_fall;
         pulsed_ff <= nxt_pulsed;
         dword_ff  <= nxt_dword;
      end
   end

   // ***********************************************
   // Sticky error and interrupt enable
   // ***********************************************
   // Set wins over clear so an illegal word in the clear cycle is kept
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         error_ff <= `LD_BIT_RST;
      end else if (word_valid && (nxt_class == OP_ILLEGAL)) begin
         error_ff <= 1'h1;
      end else if (I_ERROR_CLR) begin
         error_ff <= 1'h0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         irq_en_ff <= `LD_BIT_RST;
      end else if (word_valid && (nxt_class == OP_IRQ_ON)) begin
         irq_en_ff <= 1'h1;
      end else if (word_valid && (nxt_class == OP_IRQ_OFF)) begin
         irq_en_ff <= 1'h0;
      end
   end

   assign O_VALID       = valid_ff;
   assign O_OP_CLASS    = class_ff;
   assign O_INV_OPERAND = inv_ff;
   assign O_EDGE_RISE   = rise_ff;
   assign O_EDGE_FALL   = fall_ff;
   assign O_PULSED      = pulsed_ff;
   assign O_DWORD       = dword_ff;
   assign O_FIRE        = fire_ff;
   assign O_ILLEGAL     = illegal_ff;
   assign O_ERROR_FLAG  = error_ff;
   assign O_IRQ_ENABLE  = irq_en_ff;

   // ***********************************************
   // Assertions
   // ***********************************************
   AST_SERIES_CONTACT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4005) |=> (O_OP_CLASS == OP_AND) && O_INV_OPERAND && !O_EDGE_RISE)
      else $error("Series closed contact decoded wrongly");
   AST_PARALLEL_CONTACT: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4066) |=> (O_OP_CLASS == OP_OR) && !O_INV_OPERAND && O_FIRE)
      else $error("Parallel open contact decoded wrongly");
   AST_LOAD_EDGE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4841) |=> (O_OP_CLASS == OP_LOAD_EDGE) && O_EDGE_FALL && !O_EDGE_RISE)
      else $error("Falling load decoded wrongly");
   AST_AND_EDGE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4825) && I_OPERAND_BIT && prev_bit |=> (O_OP_CLASS == OP_AND) && !O_FIRE)
      else $error("Rising AND fired without an edge");
   AST_OR_EDGE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4826) && !I_OPERAND_BIT && prev_bit |=> O_EDGE_FALL && O_FIRE)
      else $error("Falling OR missed an edge");
   AST_NEGATE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4016) |=> (O_OP_CLASS == OP_NEGATE) && O_VALID)
      else $error("Negate decoded wrongly");
   AST_BLOCK_JOIN: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h4008) |=> O_OP_CLASS == OP_BLK_OR)
      else $error("Parallel block join decoded wrongly");
   AST_STACK: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h402A) |=> O_OP_CLASS == OP_PEEK)
      else $error("Stack peek decoded wrongly");
   AST_LATCH_ON: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h2024) |=> (O_OP_CLASS == OP_LATCH_ON) && !O_PULSED)
      else $error("Latch on decoded wrongly");
   AST_LATCH_CLEAR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h2004) |=> O_OP_CLASS == OP_LATCH_CLEAR)
      else $error("Latch clear decoded wrongly");
   AST_COIL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h2002) |=> (O_OP_CLASS == OP_COIL) && O_FIRE)
      else $error("Coil drive decoded wrongly");
   AST_EMPTY_LINE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h8011) |=> (O_OP_CLASS == OP_NOP) && !O_FIRE && $stable(O_IRQ_ENABLE))
      else $error("Empty line changed state");
   AST_LABELS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h6031) |=> O_OP_CLASS == OP_LABEL_IRQ)
      else $error("Handler label decoded wrongly");
   AST_JUMP_PULSE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h280D) |=> (O_OP_CLASS == OP_JUMP) && O_PULSED && !O_DWORD)
      else $error("Pulsed jump decoded wrongly");
   AST_CALL: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h300E) |=> O_ILLEGAL && (O_OP_CLASS == OP_ILLEGAL))
      else $error("Double width call not rejected");
   AST_LOOP: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h400C) |=> O_OP_CLASS == OP_LOOP_CLOSE)
      else $error("Loop close decoded wrongly");
   AST_IRQ_ENABLE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h8012) ##1 !(word_valid && (I_INSTR_WORD == 16'h8013))
         |-> O_IRQ_ENABLE ##1 O_IRQ_ENABLE)
      else $error("Interrupt enable not held");
   AST_COMPARE_DWORD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h3201) |=> (O_OP_CLASS == OP_COMPARE) && O_DWORD && !O_PULSED)
      else $error("Double compare decoded wrongly");
   AST_RANGE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h3202) |=> (O_OP_CLASS == OP_RANGE) && O_DWORD)
      else $error("Double zone compare decoded wrongly");
   AST_TRANSFER: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h2018) |=> (O_OP_CLASS == OP_TRANSFER) && !O_DWORD)
      else $error("Word copy decoded wrongly");
   AST_VARIANT_BITS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h3818) |=> (O_OP_CLASS == OP_TRANSFER) && O_PULSED && O_DWORD)
      else $error("Pulsed double copy decoded wrongly");
   AST_PROG_ENDS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && (I_INSTR_WORD == 16'h6023) |=> O_OP_CLASS == OP_PROG_FINISH)
      else $error("Program end decoded wrongly");
   AST_ILLEGAL_STICKY: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      O_ILLEGAL |-> O_ERROR_FLAG && !O_FIRE && (O_OP_CLASS == OP_ILLEGAL))
      else $error("Illegal word executed or not flagged");
   AST_PULSE_ONCE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      word_valid && nxt_pulsed && I_RESULT && !prev_bit |=> O_FIRE && O_PULSED)
      else $error("Pulsed variant missed its rising condition");

endmodule

// >>> tb/ladder_opcode_decoder_test.sv
// Self-checking bench for the ladder opcode decoder
module ladder_opcode_decoder_test;
   timeunit 1ns;
   timeprecision 1ns;
   import ladder_decoder_pkg::*;
   logic I_CLK_SYS = 1'h0, I_RST = 1'h1, I_INSTR_VALID = 1'h0, I_OPERAND_BIT = 1'h0;
   logic I_RESULT = 1'h0, I_ERROR_CLR = 1'h0;
   logic [7:0] I_INSTR_INDEX = 8'h00;
   logic [15:0] I_INSTR_WORD;
   logic O_VALID, O_INV_OPERAND, O_EDGE_RISE, O_EDGE_FALL, O_PULSED, O_DWORD, O_FIRE;
   logic O_ILLEGAL, O_ERROR_FLAG, O_IRQ_ENABLE;
   op_class_t O_OP_CLASS;
   int n_errors = 0;
   int n_checks = 0;
   localparam logic [15:0] CODES [42] = '{16'h4065, 16'h4005, 16'h4066, 16'h4046, 16'h4821, 16'h4841,
      16'h4825, 16'h4845, 16'h4806, 16'h4826, 16'h4016, 16'h4007, 16'h4008, 16'h4009, 16'h402A, 16'h400A,
      16'h2024, 16'h2004, 16'h2002, 16'h6003, 16'h8011, 16'h6051, 16'h6031, 16'h6023, 16'h200D, 16'h280D,
      16'h200E, 16'h280E, 16'h600F, 16'h400B, 16'h400C, 16'h6010, 16'h8012, 16'h8013, 16'h2201, 16'h3201,
      16'h2202, 16'h3202, 16'h2018, 16'h3018, 16'h2818, 16'h3818};
   localparam op_class_t CLS [42] = '{OP_AND, OP_AND, OP_OR, OP_OR, OP_LOAD_EDGE, OP_LOAD_EDGE, OP_AND,
      OP_AND, OP_OR, OP_OR, OP_NEGATE, OP_BLK_AND, OP_BLK_OR, OP_PUSH, OP_PEEK, OP_POP, OP_LATCH_ON,
      OP_LATCH_CLEAR, OP_COIL, OP_MAIN_END, OP_NOP, OP_LABEL_JUMP, OP_LABEL_IRQ, OP_PROG_FINISH, OP_JUMP,
      OP_JUMP, OP_CALL, OP_CALL, OP_SUB_RET, OP_LOOP_OPEN, OP_LOOP_CLOSE, OP_IRQ_RET, OP_IRQ_ON,
      OP_IRQ_OFF, OP_COMPARE, OP_COMPARE, OP_RANGE, OP_RANGE, OP_TRANSFER, OP_TRANSFER, OP_TRANSFER,
      OP_TRANSFER};
   always #25 I_CLK_SYS = ~I_CLK_SYS;
   ladder_program_rom rom (.i_index(I_INSTR_INDEX), .o_word(I_INSTR_WORD));
   ladder_opcode_decoder dut (
      .I_CLK_SYS     (I_CLK_SYS),
      .I_RST         (I_RST),
      .I_INSTR_VALID (I_INSTR_VALID),
      .I_INSTR_WORD  (I_INSTR_WORD),
      .I_INSTR_INDEX (I_INSTR_INDEX),
      .I_OPERAND_BIT (I_OPERAND_BIT),
      .I_RESULT      (I_RESULT),
      .I_ERROR_CLR   (I_ERROR_CLR),
      .O_VALID       (O_VALID),
      .O_OP_CLASS    (O_OP_CLASS),
      .O_INV_OPERAND (O_INV_OPERAND),
      .O_EDGE_RISE   (O_EDGE_RISE),
      .O_EDGE_FALL   (O_EDGE_FALL),
      .O_PULSED      (O_PULSED),
      .O_DWORD       (O_DWORD),
      .O_FIRE        (O_FIRE),
      .O_ILLEGAL     (O_ILLEGAL),
      .O_ERROR_FLAG  (O_ERROR_FLAG),
      .O_IRQ_ENABLE  (O_IRQ_ENABLE)
   );
   // ***********************************************
   // Shared checks
   // ***********************************************
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cb(string n, logic e, logic g);
      chk(n, {15'h0000, e}, {15'h0000, g});
   endtask
   // Word taken at one edge, answer looked at in the cycle after it
   task automatic dec(logic [15:0] w, logic [7:0] a, logic op, logic r, logic f);
      @(posedge I_CLK_SYS) #1;
      rom.put(a, w);
      I_INSTR_INDEX = a;
      I_OPERAND_BIT = op;
      I_RESULT = r;
      I_INSTR_VALID = 1'h1;
      @(posedge I_CLK_SYS) #1;
      I_INSTR_VALID = 1'h0;
      cb("valid", 1'h1, O_VALID);
      cb("fire", f, O_FIRE);
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_table;
      for (int k = 0; k < 42; k++) begin
         // Fresh line per word, so rising words fire and falling ones and the empty line do not
         dec(CODES[k], 8'(k), 1'h1, 1'h1, !(CODES[k] inside {16'h4841, 16'h4845, 16'h4826, 16'h8011}));
         chk("class", 16'(CLS[k]), 16'(O_OP_CLASS));
         chk("class", 16'(CLS[k]), 16'(O_OP_CLASS));
         cb("pulsed", CODES[k][11] & (CODES[k][15:13] == 3'h1), O_PULSED);
         cb("dword", CODES[k][12], O_DWORD);
         cb("inv", CODES[k] inside {16'h4005, 16'h4046}, O_INV_OPERAND);
         cb("rise", CODES[k] inside {16'h4821, 16'h4825, 16'h4806}, O_EDGE_RISE);
         cb("fall", CODES[k] inside {16'h4841, 16'h4845, 16'h4826}, O_EDGE_FALL);
         cb("illegal", 1'h0, O_ILLEGAL);
         if (k == 32 || k == 33) cb("irq", k == 32, O_IRQ_ENABLE);
      end
      $display("test table done");
   endtask
   task automatic t_edge;
      dec(16'h4821, 8'hC8, 1'h0, 1'h0, 1'h0);
      dec(16'h4821, 8'hC8, 1'h1, 1'h0, 1'h1);
      dec(16'h4821, 8'hC8, 1'h1, 1'h0, 1'h0);
      dec(16'h4841, 8'hC9, 1'h1, 1'h0, 1'h0);
      dec(16'h4841, 8'hC9, 1'h0, 1'h0, 1'h1);
      dec(16'h4825, 8'hCA, 1'h1, 1'h0, 1'h1);
      dec(16'h4825, 8'hCA, 1'h1, 1'h0, 1'h0);
      dec(16'h4826, 8'hCB, 1'h1, 1'h0, 1'h0);
      dec(16'h4826, 8'hCB, 1'h0, 1'h0, 1'h1);
      dec(16'h3818, 8'hD2, 1'h0, 1'h1, 1'h1);
      dec(16'h3818, 8'hD2, 1'h0, 1'h1, 1'h0);
      $display("test edge done");
   endtask
   task automatic t_illegal;
      dec(16'h300E, 8'hE0, 1'h1, 1'h1, 1'h0);
      chk("class", 16'(OP_ILLEGAL), 16'(O_OP_CLASS));
      cb("illegal", 1'h1, O_ILLEGAL);
      dec(16'h8011, 8'hE1, 1'h0, 1'h0, 1'h0);
      cb("err", 1'h1, O_ERROR_FLAG);
      I_ERROR_CLR = 1'h1;
      @(posedge I_CLK_SYS) #1;
      cb("err", 1'h0, O_ERROR_FLAG);
      // Clear still high while another illegal word is taken: the set must win
      dec(16'h300E, 8'hE2, 1'h0, 1'h0, 1'h0);
      I_ERROR_CLR = 1'h0;
      cb("err", 1'h1, O_ERROR_FLAG);
      $display("test illegal done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge I_CLK_SYS);
      #1 I_RST = 1'h0;
      chk("class", 16'(OP_NOP), 16'(O_OP_CLASS));
      t_table;
      t_edge;
      t_illegal;
      report_and_stop;
   end
   // Whole run needs about 115 cycles; allow well over three times that
   initial begin
      #30000;
      n_errors++;
      report_and_stop;
   end
endmodule

// >>> tb/ladder_program_rom.sv
// Program memory model holding ladder instruction words
module ladder_program_rom (
   input  wire logic [7:0]  i_index,
   output logic      [15:0] o_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [256];
   // Unwritten lines read as empty lines, never as unknowns
   initial foreach (mem[k]) mem[k] = 16'h8011;
   assign o_word = mem[i_index];
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      mem[a] = d;
   endtask
endmodule
